//--- core/fdsr_edge.sv
/*
 * Rising edge detector for one synchronous level.
 * Assumes the input is already synchronous to core_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module fdsr_edge #(
  parameter logic IDLE = 1'b0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Level in, pulse out
  input wire logic level,
  output logic rise
);

  logic prev_q;

  // Idle value avoids a false edge just after reset
  always_ff @(posedge core_clk) begin
    if (srst) begin
      prev_q <= IDLE;
    end else begin
      prev_q <= level;
    end
  end

  assign rise = level & ~prev_q;

endmodule // fdsr_edge

`default_nettype wire

//--- core/fdsr_regs.sv
/*
 * Floppy status A/B and drive output control registers.
 * Assumes the command engine supplies step, direction, head, write gate,
 * interrupt and DMA request levels, and a pulse on each digital input
 * register read. All inputs are synchronous to core_clk.
 */
// Summary of operation
// - Legacy floats bus on status A read; enhanced always reads.
// - Legacy floats bus on status B read; enhanced always reads.
// - Enhanced status A bit 0 is head direction, one inward, reset zero.
// - Enhanced status A bits 1,2,4 raw low pins; bit 3 head side.
// - Enhanced status A bit 5 live step; bit 6 always one.
// - Status A bit 7 shows the floppy interrupt output gated by the DMA enable.
// - Alternate status A inverts polarities; bit 6 shows DMA request output.
// - Alternate status A bit 5 latches step; cleared by input read, resets.
// - Enhanced status B bits 0,1 show motor enables; hardware reset only.
// - Enhanced status B bit 2 write gate; bits 3,4 toggle on edges.
// - Enhanced status B bit 5 mirrors drive select bit 0; bits 6,7 one.
// - Alternate status B bit 2 latches write gate rise; input read clears.
// - Alternate status B bits 3,4 latch data inactive edges, ungated.
// - Alternate status B bits 5,6 show low drive selects; rest unsupported.
// - Output control resets to zero, always writable, kept on soft reset.
// - Drive number bits assert at most one drive select at a time.
// - Bit 2 low holds controller reset and clears the status A step latch.
// - Legacy/alternate: DMA enable bit gates DMA, interrupt; request floats.
// - Enhanced mode keeps DMA and interrupt always enabled.
// - Bits 4,5 drive motor outputs 0,1 active; bits 6,7 unsupported.
// - Drive select and motor outputs are active low.
`timescale 1ns/1ps
`default_nettype none

module fdsr_regs (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Configuration
  input wire fdsr_pkg::fdsr_mode_e mode,
  // Host I/O bus
  input wire fdsr_pkg::fdsr_io_s io,
  output logic [7:0] io_rdata,
  output logic io_rdata_oe_n,
  // Command engine side
  input wire fdsr_pkg::fdsr_pins_s pins,
  input wire logic dir_read_pulse,
  output logic soft_reset_n,
  output logic ctrl_reset,
  output logic dma_irq_enable,
  // Drive interface
  output logic drive_select_out_0_n,
  output logic drive_select_out_1_n,
  output logic motor_out_0_n,
  output logic motor_out_1_n,
  // DMA request pin and gated interrupt
  output logic drq_out,
  output logic drq_oe_n,
  output logic floppy_irq_gated
);

  ////////////////////////////////////////////////////////////////////////////

  function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
    hit = (a == off);
  endfunction

  logic [7:0] drv_ctrl_q;
  logic [7:0] rdata_q;
  logic oe_q;
  logic rd_tog_q;
  logic wd_tog_q;
  logic step_rise;
  logic write_gate_out_rise;
  logic rdata_rise;
  logic wdata_rise;
  logic step_ff_q;
  logic write_gate_out_ff_q;
  logic rdata_ff_q;
  logic wdata_ff_q;
  logic enh;
  logic wr_doc;
  logic rd_stat;
  logic rd_doc;
  logic [7:0] stat_a;
  logic [7:0] stat_b;
  logic [7:0] rdata_d;

  assign enh = (mode == fdsr_pkg::FDSR_ENHANCED);
  assign wr_doc = io.wr & hit(io.addr, fdsr_pkg::OFF_DRV_CTRL);
  assign rd_doc = io.rd & hit(io.addr, fdsr_pkg::OFF_DRV_CTRL);
  assign rd_stat = io.rd & (hit(io.addr, fdsr_pkg::OFF_STATUS_A) |
                            hit(io.addr, fdsr_pkg::OFF_STATUS_B));

  ////////////////////////////////////////////////////////////////////////////
  // Drive output control

  always_ff @(posedge core_clk) begin
    if (srst) begin
      drv_ctrl_q <= fdsr_pkg::DOC_RESET;
    end else if (wr_doc) begin
      drv_ctrl_q <= io.wdata;
    end
  end

  // Soft reset never touches this register, only the engine and the status A step latch
  assign soft_reset_n = drv_ctrl_q[fdsr_pkg::DOC_NRST];
  assign ctrl_reset = srst | ~soft_reset_n;

  // Only drives 0 and 1 exist; codes 2 and 3 select nothing
  assign drive_select_out_0_n = ~(drv_ctrl_q[fdsr_pkg::DOC_SEL_HI:
    fdsr_pkg::DOC_SEL_LO] == fdsr_pkg::DRIVE_0);
  assign drive_select_out_1_n = ~(drv_ctrl_q[fdsr_pkg::DOC_SEL_HI:
    fdsr_pkg::DOC_SEL_LO] == fdsr_pkg::DRIVE_1);
  assign motor_out_0_n = ~drv_ctrl_q[fdsr_pkg::DOC_MOT0];
  assign motor_out_1_n = ~drv_ctrl_q[fdsr_pkg::DOC_MOT1];

  // Enhanced mode ignores the enable bit, even during reset
  assign dma_irq_enable =
    enh | drv_ctrl_q[fdsr_pkg::DOC_DMA_IRQ_ENABLE];
  assign drq_oe_n = ~dma_irq_enable;
  assign drq_out = pins.dma_req & dma_irq_enable;
  assign floppy_irq_gated = pins.floppy_irq_out & dma_irq_enable;

  ////////////////////////////////////////////////////////////////////////////
  // Edges and latches

  fdsr_edge #(.IDLE(1'b0)) u_step_edge (
    .core_clk(core_clk),
    .srst(srst),
    .level(pins.step_out),
    .rise(step_rise)
  );

  fdsr_edge #(.IDLE(1'b0)) u_write_gate_out_edge (
    .core_clk(core_clk),
    .srst(srst),
    .level(pins.write_gate_out),
    .rise(write_gate_out_rise)
  );

  // Data pins are active low: the inactive edge is the rising one
  fdsr_edge #(.IDLE(1'b1)) u_rdata_edge (
    .core_clk(core_clk),
    .srst(srst),
    .level(pins.read_data_n),
    .rise(rdata_rise)
  );

  fdsr_edge #(.IDLE(1'b1)) u_wdata_edge (
    .core_clk(core_clk),
    .srst(srst),
    .level(pins.write_data_n),
    .rise(wdata_rise)
  );

  fdsr_sticky u_step_ff (
    .core_clk(core_clk),
    .srst(srst),
    .set(step_rise),
    .clr(dir_read_pulse | ~soft_reset_n),
    .flag_q(step_ff_q)
  );

  fdsr_sticky u_write_gate_out_ff (
    .core_clk(core_clk),
    .srst(srst),
    .set(write_gate_out_rise),
    .clr(dir_read_pulse),
    .flag_q(write_gate_out_ff_q)
  );

  fdsr_sticky u_rdata_ff (
    .core_clk(core_clk),
    .srst(srst),
    .set(rdata_rise),
    .clr(dir_read_pulse),
    .flag_q(rdata_ff_q)
  );

  // Not qualified by write gate
  fdsr_sticky u_wdata_ff (
    .core_clk(core_clk),
    .srst(srst),
    .set(wdata_rise),
    .clr(dir_read_pulse),
    .flag_q(wdata_ff_q)
  );

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rd_tog_q <= 1'b0;
    end else if (rdata_rise) begin
      rd_tog_q <= ~rd_tog_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wd_tog_q <= 1'b0;
    end else if (wdata_rise) begin
      wd_tog_q <= ~wd_tog_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status composition

  always_comb begin
    stat_a = '0;
    stat_a[fdsr_pkg::SR_B7] = floppy_irq_gated;
    if (enh) begin
      stat_a[fdsr_pkg::SR_B0] = pins.head_dir_in;
      stat_a[fdsr_pkg::SR_B1] = pins.write_protect_n;
      stat_a[fdsr_pkg::SR_B2] = pins.index_pulse_n;
      stat_a[fdsr_pkg::SR_B3] = pins.head_side_select;
      stat_a[fdsr_pkg::SR_B4] = pins.track_zero_n;
      stat_a[fdsr_pkg::SR_B5] = pins.step_out;
      stat_a[fdsr_pkg::SR_B6] = 1'b1;
    end else begin
      stat_a[fdsr_pkg::SR_B0] = ~pins.head_dir_in;
      stat_a[fdsr_pkg::SR_B1] = ~pins.write_protect_n;
      stat_a[fdsr_pkg::SR_B2] = ~pins.index_pulse_n;
      stat_a[fdsr_pkg::SR_B3] = ~pins.head_side_select;
      stat_a[fdsr_pkg::SR_B4] = ~pins.track_zero_n;
      stat_a[fdsr_pkg::SR_B5] = step_ff_q;
      stat_a[fdsr_pkg::SR_B6] = drq_out;
    end
  end

  always_comb begin
    stat_b = '0;
    stat_b[fdsr_pkg::SR_B7] = 1'b1;
    if (enh) begin
      stat_b[fdsr_pkg::SR_B0] = drv_ctrl_q[fdsr_pkg::DOC_MOT0];
      stat_b[fdsr_pkg::SR_B1] = drv_ctrl_q[fdsr_pkg::DOC_MOT1];
      stat_b[fdsr_pkg::SR_B2] = pins.write_gate_out;
      stat_b[fdsr_pkg::SR_B3] = rd_tog_q;
      stat_b[fdsr_pkg::SR_B4] = wd_tog_q;
      stat_b[fdsr_pkg::SR_B5] = drv_ctrl_q[fdsr_pkg::DOC_SEL_LO];
      stat_b[fdsr_pkg::SR_B6] = 1'b1;
    end else begin
      // Absent drives 2, 3 and second-drive sense read inactive
      stat_b[fdsr_pkg::SR_B0] = 1'b1;
      stat_b[fdsr_pkg::SR_B1] = 1'b1;
      stat_b[fdsr_pkg::SR_B2] = write_gate_out_ff_q;
      stat_b[fdsr_pkg::SR_B3] = rdata_ff_q;
      stat_b[fdsr_pkg::SR_B4] = wdata_ff_q;
      stat_b[fdsr_pkg::SR_B5] = drive_select_out_0_n;
      stat_b[fdsr_pkg::SR_B6] = drive_select_out_1_n;
    end
  end

  always_comb begin
    if (hit(io.addr, fdsr_pkg::OFF_STATUS_A)) begin
      rdata_d = stat_a;
    end else if (hit(io.addr, fdsr_pkg::OFF_STATUS_B)) begin
      rdata_d = stat_b;
    end else begin
      rdata_d = drv_ctrl_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port: answer one cycle after the strobe, for one cycle

  always_ff @(posedge core_clk) begin
    if (srst) begin
      oe_q <= 1'b0;
    end else begin
      // Legacy mode floats the bus on status reads
      oe_q <= rd_doc |
        (rd_stat & (mode != fdsr_pkg::FDSR_LEGACY));
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdata_q <= '0;
    end else if (rd_doc | rd_stat) begin
      rdata_q <= rdata_d;
    end
  end

  assign io_rdata = rdata_q;
  assign io_rdata_oe_n = ~oe_q;

  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  AST_LEGACY_FLOAT: assert property (
    mode == fdsr_pkg::FDSR_LEGACY && rd_stat |=> io_rdata_oe_n)
    else $error("status read drove bus in legacy mode");

  AST_ENH_STATUS_A: assert property (
    enh && io.rd && hit(io.addr, fdsr_pkg::OFF_STATUS_A) |=>
      !io_rdata_oe_n && io_rdata[fdsr_pkg::SR_B6] &&
      io_rdata[fdsr_pkg::SR_B0] == $past(pins.head_dir_in))
    else $error("enhanced status A read wrong");

  AST_ENH_STATUS_B: assert property (
    enh && io.rd && hit(io.addr, fdsr_pkg::OFF_STATUS_B) |=>
      io_rdata[fdsr_pkg::SR_B7:fdsr_pkg::SR_B6] == 2'b11 &&
      io_rdata[fdsr_pkg::SR_B5] == $past(drv_ctrl_q[fdsr_pkg::DOC_SEL_LO]))
    else $error("enhanced status B read wrong");

  AST_DOC_WRITE: assert property (
    wr_doc |=> drv_ctrl_q == $past(io.wdata) &&
      ctrl_reset == !$past(io.wdata[fdsr_pkg::DOC_NRST]))
    else $error("control write not taken");

  AST_DOC_HOLD: assert property (
    !wr_doc |=> $stable(drv_ctrl_q))
    else $error("control register changed without write");

  AST_ONE_SELECT: assert property (
    !(!drive_select_out_0_n && !drive_select_out_1_n))
    else $error("two drive selects active");

  AST_MOTOR_ON: assert property (
    wr_doc && io.wdata[fdsr_pkg::DOC_MOT1] |=> !motor_out_1_n)
    else $error("motor output not active");

  AST_DMA_FLOAT: assert property (
    drq_oe_n |-> !enh && !drv_ctrl_q[fdsr_pkg::DOC_DMA_IRQ_ENABLE] && !drq_out)
    else $error("DMA request enable wrong");

  AST_STEP_LATCH: assert property (
    step_rise |=> step_ff_q ##1 (step_ff_q || $past(dir_read_pulse) ||
      $past(ctrl_reset)))
    else $error("step latch lost");

  AST_WRITE_GATE_OUT_CLEAR: assert property (
    dir_read_pulse && !write_gate_out_rise |=> !write_gate_out_ff_q)
    else $error("write gate latch not cleared");

  AST_RD_TOGGLE: assert property (
    rdata_rise |=> rd_tog_q != $past(rd_tog_q))
    else $error("read data toggle missed");

endmodule // fdsr_regs

`default_nettype wire

//--- core/fdsr_sticky.sv
/*
 * Sticky flag: set by an event, cleared by a strobe or reset.
 * Assumes all inputs synchronous to core_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module fdsr_sticky (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Set and clear
  input wire logic set,
  input wire logic clr,
  output logic flag_q
);

  // Set beats clear so a coincident event is kept
  always_ff @(posedge core_clk) begin
    if (srst) begin
      flag_q <= 1'b0;
    end else if (set) begin
      flag_q <= 1'b1;
    end else if (clr) begin
      flag_q <= 1'b0;
    end
  end

endmodule // fdsr_sticky

`default_nettype wire

//--- dv/fdsr_drive_model.sv
/*
 * Behavioural drive and command-engine levels for the register bench.
 * Assumes one drive on select 0 and pull-ups on its status lines.
 */
`timescale 1ns/1ps
`default_nettype none

module fdsr_drive_model (
  // Clock
  input wire logic core_clk,
  // Select from the block
  input wire logic drive_select_out_0_n,
  // Levels seen by the block
  output logic [10:0] pins
);
  logic [10:0] lv = 11'h70C;

  ////////////////////////////////////////////////////////////////////////
  // Deselected drive releases its lines, so pull-ups win
  always_comb begin
    pins = lv;
    if (drive_select_out_0_n) begin
      pins[10] = 1'b1;
      pins[9] = 1'b1;
      pins[8] = 1'b1;
      pins[3] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic put(input logic [10:0] v);
    @(posedge core_clk);
    lv <= v;
  endtask

  task automatic pulse(input int k);
    @(posedge core_clk);
    lv[k] <= ~lv[k];
    @(posedge core_clk);
    lv[k] <= ~lv[k];
  endtask
endmodule // fdsr_drive_model

`default_nettype wire

//--- dv/tb_floppy_status_output_regs.sv
/*
 * Self-checking bench for the floppy status and output registers.
 * Assumes fdsr_pkg and the drive model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end

module tb_floppy_status_output_regs;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  fdsr_pkg::fdsr_mode_e mode = fdsr_pkg::FDSR_LEGACY;
  fdsr_pkg::fdsr_io_s io = '0;
  logic dir_read_pulse = 1'b0;
  logic [10:0] pins;
  fdsr_pkg::fdsr_pins_s pins_s;
  logic [7:0] io_rdata, rd_d;
  logic io_rdata_oe_n, soft_reset_n, ctrl_reset, dma_irq_enable, rd_oe;
  logic drive_select_out_0_n, drive_select_out_1_n;
  logic motor_out_0_n, motor_out_1_n, drq_out, drq_oe_n, floppy_irq_gated;
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;

  fdsr_regs uut (
    .core_clk(core_clk), .srst(srst), .mode(mode), .io(io),
    .io_rdata(io_rdata), .io_rdata_oe_n(io_rdata_oe_n),
    .pins(pins_s), .dir_read_pulse(dir_read_pulse),
    .soft_reset_n(soft_reset_n), .ctrl_reset(ctrl_reset),
    .dma_irq_enable(dma_irq_enable),
    .drive_select_out_0_n(drive_select_out_0_n),
    .drive_select_out_1_n(drive_select_out_1_n),
    .motor_out_0_n(motor_out_0_n), .motor_out_1_n(motor_out_1_n),
    .drq_out(drq_out), .drq_oe_n(drq_oe_n),
    .floppy_irq_gated(floppy_irq_gated));

  assign pins_s = pins;

  fdsr_drive_model drv (
    .core_clk(core_clk), .drive_select_out_0_n(drive_select_out_0_n),
    .pins(pins));

  initial begin
    forever #10 core_clk = ~core_clk;
  end

  // Hang guard, far above the under 200 cycles the run needs
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic rst(input fdsr_pkg::fdsr_mode_e m);
    @(posedge core_clk);
    mode <= m;
    srst <= 1'b1;
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    #1;
  endtask

  task automatic rd(input logic [15:0] a);
    @(posedge core_clk);
    io.rd <= 1'b1;
    io.addr <= a;
    @(posedge core_clk);
    io.rd <= 1'b0;
    #1;
    rd_oe = io_rdata_oe_n;
    rd_d = io_rdata;
  endtask

  task automatic rchk(input logic [15:0] a, input logic [7:0] e);
    rd(a);
    `CHK(rd_oe, 1'b0)
    `CHK(rd_d, e)
  endtask

  task automatic wr(input logic [7:0] v);
    @(posedge core_clk);
    io.wr <= 1'b1;
    io.addr <= fdsr_pkg::OFF_DRV_CTRL;
    io.wdata <= v;
    @(posedge core_clk);
    io.wr <= 1'b0;
    @(posedge core_clk);
    #1;
  endtask

  task automatic dirp();
    @(posedge core_clk);
    dir_read_pulse <= 1'b1;
    @(posedge core_clk);
    dir_read_pulse <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_legacy();
    rst(fdsr_pkg::FDSR_LEGACY);
    `CHK({drive_select_out_1_n, drive_select_out_0_n}, 2'b10)
    `CHK({motor_out_1_n, motor_out_0_n, soft_reset_n, ctrl_reset}, 4'hD)
    rchk(fdsr_pkg::OFF_DRV_CTRL, fdsr_pkg::DOC_RESET);
    rd(fdsr_pkg::OFF_STATUS_A);
    `CHK(rd_oe, 1'b1)
    rd(fdsr_pkg::OFF_STATUS_B);
    `CHK(rd_oe, 1'b1)
    drv.put(11'h70F);
    repeat (2) @(posedge core_clk);
    #1;
    `CHK({drq_oe_n, floppy_irq_gated, dma_irq_enable}, 3'b100)
    wr(8'h0C);
    `CHK({drq_oe_n, drq_out, floppy_irq_gated, dma_irq_enable}, 4'h7)
    wr(8'h0E);
    `CHK({drive_select_out_1_n, drive_select_out_0_n}, 2'b11)
    wr(8'h2D);
    `CHK({drive_select_out_1_n, drive_select_out_0_n, motor_out_1_n, motor_out_0_n}, 4'h5)
    rchk(fdsr_pkg::OFF_DRV_CTRL, 8'h2D);
  endtask

  task automatic t_enhanced();
    rst(fdsr_pkg::FDSR_ENHANCED);
    `CHK({drq_oe_n, dma_irq_enable}, 2'b01)
    rchk(fdsr_pkg::OFF_DRV_CTRL, 8'h00);
    drv.put(11'h2EE);
    repeat (3) @(posedge core_clk);
    rchk(fdsr_pkg::OFF_STATUS_A, 8'hED);
    drv.put(11'h70C);
    wr(8'h34);
    drv.pulse(3);
    drv.pulse(2);
    drv.put(11'h71C);
    repeat (3) @(posedge core_clk);
    rchk(fdsr_pkg::OFF_STATUS_B, 8'hDF);
    wr(8'h35);
    rchk(fdsr_pkg::OFF_STATUS_B, 8'hFF);
    wr(8'h31);
    `CHK({soft_reset_n, ctrl_reset}, 2'b01)
    rchk(fdsr_pkg::OFF_STATUS_B, 8'hFF);
    rchk(fdsr_pkg::OFF_DRV_CTRL, 8'h31);
    repeat (fdsr_pkg::SOFT_RST_MIN_CYC) @(posedge core_clk);
    wr(8'h35);
    `CHK({soft_reset_n, ctrl_reset, drive_select_out_1_n, drive_select_out_0_n, motor_out_1_n, motor_out_0_n}, 6'h24)
  endtask

  task automatic t_alternate();
    // Write gate low before reset ends, as the engine would hold it
    drv.put(11'h2CF);
    rst(fdsr_pkg::FDSR_ALTERNATE);
    repeat (2) @(posedge core_clk);
    #1;
    `CHK({drq_oe_n, floppy_irq_gated}, 2'b10)
    rchk(fdsr_pkg::OFF_STATUS_B, 8'hC3);
    wr(8'h0C);
    drv.pulse(5);
    repeat (2) @(posedge core_clk);
    rchk(fdsr_pkg::OFF_STATUS_A, 8'hF2);
    dirp();
    rchk(fdsr_pkg::OFF_STATUS_A, 8'hD2);
    drv.pulse(5);
    wr(8'h08);
    rchk(fdsr_pkg::OFF_STATUS_A, 8'hD2);
    repeat (fdsr_pkg::SOFT_RST_MIN_CYC) @(posedge core_clk);
    wr(8'h0C);
    drv.pulse(2);
    drv.pulse(3);
    drv.put(11'h2DF);
    repeat (2) @(posedge core_clk);
    rchk(fdsr_pkg::OFF_STATUS_B, 8'hDF);
    dirp();
    rchk(fdsr_pkg::OFF_STATUS_B, 8'hC3);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    t_legacy();
    t_enhanced();
    t_alternate();
    finish_test();
  end
endmodule // tb_floppy_status_output_regs

`default_nettype wire

//--- include/fdsr_pkg.sv
/*
 * Shared constants and carriers for the floppy status/output registers.
 * Assumes an 8-bit host I/O bus with 16-bit address qualification.
 */
package fdsr_pkg;

  // Register offsets on the host I/O bus
  localparam logic [15:0] OFF_STATUS_A = 16'h03F0;
  localparam logic [15:0] OFF_STATUS_B = 16'h03F1;
  localparam logic [15:0] OFF_DRV_CTRL = 16'h03F2;

  // Drive output control fields
  localparam int DOC_SEL_LO = 0;
  localparam int DOC_SEL_HI = 1;
  localparam int DOC_NRST = 2;
  localparam int DOC_DMA_IRQ_ENABLE = 3;
  localparam int DOC_MOT0 = 4;
  localparam int DOC_MOT1 = 5;
  localparam logic [7:0] DOC_RESET = 8'h00;

  // Drive numbers
  localparam logic [1:0] DRIVE_0 = 2'h0;
  localparam logic [1:0] DRIVE_1 = 2'h1;

  // Status register field positions
  localparam int SR_B0 = 0;
  localparam int SR_B1 = 1;
  localparam int SR_B2 = 2;
  localparam int SR_B3 = 3;
  localparam int SR_B4 = 4;
  localparam int SR_B5 = 5;
  localparam int SR_B6 = 6;
  localparam int SR_B7 = 7;

  // Least software reset the host must hold
  localparam int CLK_PERIOD_NS = 20;
  localparam int SOFT_RST_MIN_NS = 100;
  localparam int SOFT_RST_MIN_CYC =
    (SOFT_RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    FDSR_LEGACY,
    FDSR_ENHANCED,
    FDSR_ALTERNATE
  } fdsr_mode_e;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic rd;
    logic wr;
  } fdsr_io_s;

  typedef struct packed {
    logic write_protect_n;
    logic index_pulse_n;
    logic track_zero_n;
    logic head_side_select;
    logic head_dir_in;
    logic step_out;
    logic write_gate_out;
    logic read_data_n;
    logic write_data_n;
    logic floppy_irq_out;
    logic dma_req;
  } fdsr_pins_s;

endpackage
